// *** include/scrc_pkg.sv ***
// constants for the strap-selected clock ratio block
package scrc_pkg;
    localparam int unsigned CLK_PERIOD_NS = 40;
    localparam int unsigned PLL_LOCK_NS   = 100000;
    localparam int unsigned LOCK_CYC      = (PLL_LOCK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned NUM_PLL       = 5;
    localparam int unsigned PLL_PLAT      = 0;
    localparam int unsigned PLL_CORE      = 1;
    localparam int unsigned PLL_EXP       = 2;
    localparam int unsigned PLL_LBUS      = 3;
    localparam int unsigned PLL_SERIAL    = 4;
    localparam int unsigned MEM_DIV_SHIFT = 1;

    localparam logic [7:0] OFF_STATUS   = 8'h00;
    localparam logic [7:0] OFF_CTRL     = 8'h04;
    localparam logic [7:0] OFF_PLAT_KHZ = 8'h08;
    localparam logic [7:0] OFF_CORE_KHZ = 8'h0C;
    localparam logic [7:0] OFF_MEM_KHZ  = 8'h10;

    localparam int unsigned ST_PLAT_STRAP_LSB = 0;
    localparam int unsigned ST_CORE_STRAP_LSB = 4;
    localparam int unsigned ST_PLAT_RSV_BIT   = 7;
    localparam int unsigned ST_CORE_RSV_BIT   = 8;
    localparam int unsigned ST_LOCK_LSB       = 9;
    localparam int unsigned ST_SAMPLED_BIT    = 14;

    localparam logic [4:0] CTRL_RESET = 5'h1F;
endpackage

// *** src/scrc_strap_clock_ratio.sv ***
// strap sampling, ratio decode and clock frequency bookkeeping
//
// Local design decisions: the placing of the registers and the plain strobed port.
`timescale 1ns/1ns
`default_nettype none

// Summary of operation
// - sample four platform straps at power-up
// - decode platform multiplier; reserved codes give zero
// - sample three core straps at power-up
// - decode core ratio in halves; 010 reserved
// - platform clock is reference times multiplier
// - core clock slaves to locked platform clock
// - platform and bus clock are one clock
// - memory bus clock is half platform clock
// - five PLLs: platform, core, expansion, local, serial
module scrc_strap_clock_ratio (
    input  wire logic        CORE_CLK,
    input  wire logic        RST,
    input  wire logic [3:0]  PLATFORM_RATIO_STRAPS,
    input  wire logic        BUFFER_CONTROL_STRAP,
    input  wire logic        ADDRESS_LATCH_STRAP,
    input  wire logic        GENERAL_LINE_TWO_STRAP,
    input  wire logic [31:0] REF_FREQ_KHZ,
    input  wire logic [7:0]  ADDR,
    input  wire logic [31:0] WR_DATA,
    input  wire logic        WR_STB,
    input  wire logic        RD_STB,
    output logic      [31:0] RD_DATA,
    output logic      [4:0]  PLAT_MULT,
    output logic      [3:0]  CORE_HALVES,
    output logic      [4:0]  PLL_LOCKED,
    output logic      [31:0] PLAT_KHZ,
    output logic      [31:0] CORE_KHZ,
    output logic      [31:0] MEM_KHZ
);
    logic        sampled_r,    sampled_nxt;
    logic [3:0]  plat_strap_r, plat_strap_nxt;
    logic [2:0]  core_strap_r, core_strap_nxt;
    logic [4:0]  mult_r,       mult_nxt;
    logic [3:0]  halves_r,     halves_nxt;
    logic [4:0]  ctrl_r,       ctrl_nxt;
    logic [31:0] rd_data_r,    rd_data_nxt;
    logic [31:0] plat_khz_r,   plat_khz_nxt;
    logic [31:0] core_khz_r,   core_khz_nxt;
    logic [31:0] mem_khz_r,    mem_khz_nxt;
    logic [4:0]  locked_r;
    logic [4:0]  pll_go;
    logic [4:0]  dec_mult;
    logic [3:0]  dec_halves;
    logic [2:0]  core_pins;
    logic [36:0] plat_prod;
    logic [35:0] core_prod;

    assign core_pins = {BUFFER_CONTROL_STRAP, ADDRESS_LATCH_STRAP, GENERAL_LINE_TWO_STRAP};

    // strap decode; zero marks a reserved code
    always_comb begin
        case (PLATFORM_RATIO_STRAPS)
            4'h0:    dec_mult = 5'd16;
            4'h2:    dec_mult = 5'd2;
            4'h3:    dec_mult = 5'd3;
            4'h4:    dec_mult = 5'd4;
            4'h5:    dec_mult = 5'd5;
            4'h6:    dec_mult = 5'd6;
            4'h8:    dec_mult = 5'd8;
            4'h9:    dec_mult = 5'd9;
            4'hA:    dec_mult = 5'd10;
            4'hC:    dec_mult = 5'd12;
            4'hD:    dec_mult = 5'd20;
            default: dec_mult = 5'd0;
        endcase
        case (core_pins)
            3'b000:  dec_halves = 4'd8;
            3'b001:  dec_halves = 4'd9;
            3'b011:  dec_halves = 4'd3;
            3'b100:  dec_halves = 4'd4;
            3'b101:  dec_halves = 4'd5;
            3'b110:  dec_halves = 4'd6;
            3'b111:  dec_halves = 4'd7;
            default: dec_halves = 4'd0;
        endcase
    end

    // capture once, on the first edge after reset release, then hold
    always_comb begin
        sampled_nxt    = 1'b1;
        plat_strap_nxt = plat_strap_r;
        core_strap_nxt = core_strap_r;
        mult_nxt       = mult_r;
        halves_nxt     = halves_r;
        if (!sampled_r) begin
            plat_strap_nxt = PLATFORM_RATIO_STRAPS;
            core_strap_nxt = core_pins;
            mult_nxt       = dec_mult;
            halves_nxt     = dec_halves;
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            sampled_r    <= 1'b0;
            plat_strap_r <= 4'h0;
            core_strap_r <= 3'h0;
            mult_r       <= 5'h00;
            halves_r     <= 4'h0;
        end else begin
            sampled_r    <= sampled_nxt;
            plat_strap_r <= plat_strap_nxt;
            core_strap_r <= core_strap_nxt;
            mult_r       <= mult_nxt;
            halves_r     <= halves_nxt;
        end
    end

    // pll start conditions; core waits for platform lock
    always_comb begin
        pll_go = ctrl_r & {5{sampled_r}};
        pll_go[scrc_pkg::PLL_PLAT] = pll_go[scrc_pkg::PLL_PLAT] && (mult_r != 5'd0);
        // core drops in the same cycle as the platform pll, never after it
        pll_go[scrc_pkg::PLL_CORE] = pll_go[scrc_pkg::PLL_CORE] && (halves_r != 4'd0)
                                     && locked_r[scrc_pkg::PLL_PLAT]
                                     && pll_go[scrc_pkg::PLL_PLAT];
    end

    genvar gi;
    generate
        for (gi = 0; gi < scrc_pkg::NUM_PLL; gi++) begin : g_pll
            logic [11:0] cnt_r, cnt_nxt;
            logic        lk_nxt;
            always_comb begin
                cnt_nxt = 12'h000;
                lk_nxt  = 1'b0;
                if (pll_go[gi]) begin
                    lk_nxt  = (cnt_r == 12'(scrc_pkg::LOCK_CYC - 1));
                    cnt_nxt = lk_nxt ? cnt_r : cnt_r + 12'h001;
                end
            end
            always_ff @(posedge CORE_CLK) begin
                if (RST) begin
                    cnt_r        <= 12'h000;
                    locked_r[gi] <= 1'b0;
                end else begin
                    cnt_r        <= cnt_nxt;
                    locked_r[gi] <= lk_nxt;
                end
            end
        end
    endgenerate

    // frequency bookkeeping, register bus
    always_comb begin
        plat_prod    = {5'h00, REF_FREQ_KHZ} * {32'h0000_0000, mult_r};
        plat_khz_nxt = locked_r[scrc_pkg::PLL_PLAT] ? plat_prod[31:0] : 32'h0000_0000;
        core_prod    = {4'h0, plat_khz_nxt} * {32'h0000_0000, halves_r};
        core_khz_nxt = locked_r[scrc_pkg::PLL_CORE] ? core_prod[32:1] : 32'h0000_0000;
        mem_khz_nxt  = plat_khz_nxt >> scrc_pkg::MEM_DIV_SHIFT;
        ctrl_nxt     = ctrl_r;
        if (WR_STB && ADDR == scrc_pkg::OFF_CTRL) begin
            ctrl_nxt = WR_DATA[4:0];
        end
        rd_data_nxt = 32'h0000_0000;
        if (RD_STB) begin
            case (ADDR)
                scrc_pkg::OFF_STATUS: begin
                    rd_data_nxt[scrc_pkg::ST_PLAT_STRAP_LSB +: 4] = plat_strap_r;
                    rd_data_nxt[scrc_pkg::ST_CORE_STRAP_LSB +: 3] = core_strap_r;
                    rd_data_nxt[scrc_pkg::ST_PLAT_RSV_BIT] = sampled_r && (mult_r == 5'd0);
                    rd_data_nxt[scrc_pkg::ST_CORE_RSV_BIT] = sampled_r && (halves_r == 4'd0);
                    rd_data_nxt[scrc_pkg::ST_LOCK_LSB +: 5] = locked_r;
                    rd_data_nxt[scrc_pkg::ST_SAMPLED_BIT]  = sampled_r;
                end
                scrc_pkg::OFF_CTRL:     rd_data_nxt[4:0] = ctrl_r;
                scrc_pkg::OFF_PLAT_KHZ: rd_data_nxt = plat_khz_r;
                scrc_pkg::OFF_CORE_KHZ: rd_data_nxt = core_khz_r;
                scrc_pkg::OFF_MEM_KHZ:  rd_data_nxt = mem_khz_r;
                default:                rd_data_nxt = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            ctrl_r     <= scrc_pkg::CTRL_RESET;
            rd_data_r  <= 32'h0000_0000;
            plat_khz_r <= 32'h0000_0000;
            core_khz_r <= 32'h0000_0000;
            mem_khz_r  <= 32'h0000_0000;
        end else begin
            ctrl_r     <= ctrl_nxt;
            rd_data_r  <= rd_data_nxt;
            plat_khz_r <= plat_khz_nxt;
            core_khz_r <= core_khz_nxt;
            mem_khz_r  <= mem_khz_nxt;
        end
    end

    // platform clock also serves as the bus clock
    assign RD_DATA     = rd_data_r;
    assign PLAT_MULT   = mult_r;
    assign CORE_HALVES = halves_r;
    assign PLL_LOCKED  = locked_r;
    assign PLAT_KHZ    = plat_khz_r;
    assign CORE_KHZ    = core_khz_r;
    assign MEM_KHZ     = mem_khz_r;

    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (RST);

    // sampled reset in the antecedent: release lands on a clock edge
    AST_CAPTURE_PLAT: assert property (!RST && !sampled_r |=> sampled_r
        && plat_strap_r == $past(PLATFORM_RATIO_STRAPS)) else $error("platform strap not captured");
    AST_CAPTURE_CORE: assert property (!RST && !sampled_r |=> core_strap_r == $past(core_pins))
        else $error("core strap not captured");
    AST_STRAP_HOLD: assert property (sampled_r |=> $stable(plat_strap_r)
        && $stable(core_strap_r) && $stable(mult_r)) else $error("straps changed after capture");
    AST_PLAT_DECODE: assert property (sampled_r && plat_strap_r == 4'hD |-> mult_r == 5'd20
        ) else $error("platform code 1101 not 20");
    AST_PLAT_RSV: assert property (sampled_r && (plat_strap_r == 4'h1 || plat_strap_r == 4'hF)
        |-> mult_r == 5'd0 ##1 !locked_r[0]) else $error("reserved platform code used");
    AST_CORE_DECODE: assert property (sampled_r && core_strap_r == 3'b001 |-> halves_r == 4'd9
        ) else $error("core code 001 not 9:2");
    AST_CORE_SLAVE: assert property (locked_r[1] |-> locked_r[0] && halves_r != 4'd0)
        else $error("core pll locked without platform");
    AST_PLAT_FREQ: assert property (locked_r[0] && $stable(locked_r[0]) |->
        plat_khz_r == 32'($past(REF_FREQ_KHZ) * $past(mult_r))) else $error("platform freq wrong");
    AST_MEM_HALF: assert property (mem_khz_r == {1'b0, plat_khz_r[31:1]})
        else $error("memory clock not half platform");
    AST_PLL_OFF: assert property (!ctrl_r[2] |=> !locked_r[2] [*2])
        else $error("disabled pll reports lock");

    COV_PLAT_LOCK: cover property ($rose(locked_r[0]));
    COV_CORE_LOCK: cover property ($rose(locked_r[1]));
    COV_RSV_CORE:  cover property (sampled_r && halves_r == 4'd0);
    COV_READ:      cover property (RD_STB && ADDR == scrc_pkg::OFF_STATUS);
endmodule

`default_nettype wire

// *** testbench/scrc_board_model.sv ***
// board strap resistors and reference clock source
`timescale 1ns/1ns
`default_nettype none
module scrc_board_model (
    input  wire logic [3:0]  plat_code,
    input  wire logic [2:0]  core_code,
    input  wire logic [31:0] ref_khz,
    input  wire logic        scramble,
    output logic      [3:0]  plat_straps,
    output logic      [2:0]  core_straps,
    output logic      [31:0] ref_freq
);
    // every strap is driven; scramble models later reuse of the shared pins
    assign plat_straps = scramble ? ~plat_code : plat_code;
    assign core_straps = scramble ? ~core_code : core_code;
    assign ref_freq    = ref_khz;
endmodule
`default_nettype wire

// *** testbench/scrc_strap_clock_ratio_bench.sv ***
// self-checking bench for strap sampling and clock bookkeeping
`timescale 1ns/1ns
`default_nettype none
module scrc_strap_clock_ratio_bench;
    logic        clk = 0, rst = 1, wr = 0, rd = 0, scr = 0;
    logic [3:0]  pc = 0, ps;
    logic [2:0]  cc = 0, cs;
    logic [31:0] rk = 32'h0000_0000, rf, wd = 0, rdat, pk, ck, mk, d;
    logic [7:0]  ad = 0;
    logic [4:0]  pm, lk;
    logic [3:0]  ch;
    int          n_fail = 0, total_checks = 0, cyc = 0;
    logic [4:0]  ptab [16] = '{5'h10, 5'h00, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h00,
                               5'h08, 5'h09, 5'h0A, 5'h00, 5'h0C, 5'h14, 5'h00, 5'h00};
    logic [3:0]  ctab [8] = '{4'h8, 4'h9, 4'h0, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7};
    initial forever #20 clk = ~clk;
    scrc_board_model u_scrc_board_model (.plat_code(pc), .core_code(cc), .ref_khz(rk),
        .scramble(scr), .plat_straps(ps), .core_straps(cs), .ref_freq(rf));
    scrc_strap_clock_ratio u_scrc_strap_clock_ratio (.CORE_CLK(clk), .RST(rst),
        .PLATFORM_RATIO_STRAPS(ps), .BUFFER_CONTROL_STRAP(cs[2]),
        .ADDRESS_LATCH_STRAP(cs[1]), .GENERAL_LINE_TWO_STRAP(cs[0]), .REF_FREQ_KHZ(rf),
        .ADDR(ad), .WR_DATA(wd), .WR_STB(wr), .RD_STB(rd), .RD_DATA(rdat), .PLAT_MULT(pm),
        .CORE_HALVES(ch), .PLL_LOCKED(lk), .PLAT_KHZ(pk), .CORE_KHZ(ck), .MEM_KHZ(mk));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            stop_test();
        end
    end
    task automatic do_reset();
        @(posedge clk);
        rst <= 1'b1;
        repeat (7) @(posedge clk);
        #1;
        chk({27'h0, lk}, 32'h0000_0000);
        chk(pk, 32'h0000_0000);
        chk(ck, 32'h0000_0000);
        chk(mk, 32'h0000_0000);
        @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1;
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        ad <= a;
        wd <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
        @(posedge clk);
        ad <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        v = rdat;
    endtask
    task automatic wait_lock(input int idx, input logic lvl);
        int n;
        n = 0;
        while (lk[idx] !== lvl && n < 3000) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk({31'h0, lk[idx]}, {31'h0, lvl});
    endtask
    task automatic test_decode();
        for (int i = 0; i < 16; i++) begin
            @(posedge clk);
            pc <= i[3:0];
            cc <= i[2:0];
            do_reset();
            chk({27'h0, pm}, {27'h0, ptab[i]});
            chk({28'h0, ch}, {28'h0, ctab[i % 8]});
            rd_reg(scrc_pkg::OFF_STATUS, d);
            chk({25'h0, d[6:0]}, {25'h0, i[2:0], i[3:0]});
            chk({30'h0, d[8:7]}, {30'h0, ctab[i % 8] == 4'h0, ptab[i] == 5'h00});
        end
        $display("test decode done");
    endtask
    task automatic test_hold();
        @(posedge clk);
        pc <= 4'h4;
        cc <= 3'h4;
        rk <= 32'h0001_86A0;
        do_reset();
        @(posedge clk);
        scr <= 1'b1;
        rd_reg(pkg_off(0), d);
        chk(d, 32'h0000_4044);
        chk({27'h0, pm}, 32'h0000_0004);
        chk({28'h0, ch}, 32'h0000_0004);
        @(posedge clk);
        #1;
        chk(rdat, 32'h0000_0000);
        @(posedge clk);
        scr <= 1'b0;
        $display("test hold done");
    endtask
    function automatic logic [7:0] pkg_off(input int k);
        return (k == 0) ? scrc_pkg::OFF_STATUS : (k == 1) ? scrc_pkg::OFF_PLAT_KHZ :
               (k == 2) ? scrc_pkg::OFF_MEM_KHZ : scrc_pkg::OFF_CORE_KHZ;
    endfunction
    task automatic test_clocks();
        wr_reg(pkg_off(1), 32'h0000_0000);
        rd_reg(scrc_pkg::OFF_CTRL, d);
        chk(d, {27'h0, scrc_pkg::CTRL_RESET});
        wait_lock(0, 1'b1);
        repeat (2) @(posedge clk);
        #1;
        chk(pk, 32'h0006_1A80);
        chk(mk, 32'h0003_0D40);
        rd_reg(pkg_off(2), d);
        chk(d, 32'h0003_0D40);
        chk(ck, 32'h0000_0000);
        wait_lock(1, 1'b1);
        repeat (2) @(posedge clk);
        #1;
        chk(ck, 32'h000C_3500);
        rd_reg(pkg_off(3), d);
        chk(d, 32'h000C_3500);
        chk({27'h0, lk}, 32'h0000_001F);
        rd_reg(8'h20, d);
        chk(d, 32'h0000_0000);
        wr_reg(scrc_pkg::OFF_CTRL, 32'h0000_001A);
        wait_lock(0, 1'b0);
        rd_reg(scrc_pkg::OFF_CTRL, d);
        chk(d, 32'h0000_001A);
        repeat (3) @(posedge clk);
        #1;
        chk(pk, 32'h0000_0000);
        chk(ck, 32'h0000_0000);
        chk(mk, 32'h0000_0000);
        chk({27'h0, lk}, 32'h0000_0018);
        do_reset();
        rd_reg(scrc_pkg::OFF_CTRL, d);
        chk(d, {27'h0, scrc_pkg::CTRL_RESET});
        chk({27'h0, pm}, 32'h0000_0004);
        $display("test clocks done");
    endtask
    initial begin
        test_decode();
        test_hold();
        test_clocks();
        stop_test();
    end
endmodule
`default_nettype wire
